// *** logic/cap_pkg.sv ***
// Package with constants and carrier types of the timer slice capture block
package cap_pkg;
  localparam int          TIMER_W       = 16;
  localparam int          SEL_W         = 2;
  localparam int          NUM_REGS      = 4;
  localparam logic [1:0]  SEL_UNUSED    = 2'h0;
  localparam logic [15:0] TIMER_RST     = 16'h0000;
  localparam logic [15:0] PERIOD_RST    = 16'hffff;

  typedef struct packed {
    logic [SEL_W-1:0] trigger0_select;
    logic [SEL_W-1:0] trigger1_select;
    logic             depth4_mode;
    logic             timer_run;
  } slice_connection_control_type;

  typedef struct packed {
    logic [NUM_REGS-1:0][TIMER_W-1:0] cap;
    logic [NUM_REGS-1:0]              full;
    logic [TIMER_W-1:0]               timer;
    logic                             period_irq;
    logic                             period_match;
  } state_type;
endpackage : cap_pkg

// *** logic/timer_slice_capture_fifo.sv ***
// Capture side of one timer slice: timer, capture FIFOs, period event
`timescale 1ns/1ns
module timer_slice_capture_fifo #(
  parameter logic [15:0] PERIOD_DEFAULT = cap_pkg::PERIOD_RST
) (
  // Clock and reset
  input  wire logic                                  ref_clk_i,
  input  wire logic                                  rst_i,
  // Configuration
  input  wire cap_pkg::slice_connection_control_type ctrl_i,
  input  wire logic [cap_pkg::TIMER_W-1:0]           period_i,
  // Trigger events, one-cycle pulses
  input  wire logic                                  trigger0_i,
  input  wire logic                                  trigger1_i,
  // Capture results
  output logic [cap_pkg::NUM_REGS-1:0][cap_pkg::TIMER_W-1:0] cap_o,
  output logic [cap_pkg::NUM_REGS-1:0]               full_o,
  output logic [cap_pkg::TIMER_W-1:0]                timer_o,
  // Period event
  output logic                                       period_irq_o
);

  cap_pkg::state_type s_q;
  cap_pkg::state_type s_d;

  //////////////////////////////////////////////////////////////////////////
  // Local carrier types
  typedef logic [cap_pkg::TIMER_W-1:0]       value_type;
  typedef value_type [1:0]                   pair_type;
  typedef value_type [cap_pkg::NUM_REGS-1:0] quad_type;

  //////////////////////////////////////////////////////////////////////////
  // Decoding helpers

  // An all-zero selection field leaves its trigger unconnected, except trigger 1 in depth-4 mode
  function automatic logic select_active(
    input logic [cap_pkg::SEL_W-1:0] sel
  );
    return (sel != cap_pkg::SEL_UNUSED);
  endfunction : select_active

  // Trigger 0 has no registers of its own in depth-4 mode
  function automatic logic trigger0_enabled(
    input cap_pkg::slice_connection_control_type ctrl
  );
    logic enabled;
    enabled = select_active(ctrl.trigger0_select);
    if (ctrl.depth4_mode) begin
      enabled = 1'b0;
    end
    return enabled;
  endfunction : trigger0_enabled

  // Depth-4 mode listens on trigger 1 whatever its selection
  function automatic logic trigger1_enabled(
    input cap_pkg::slice_connection_control_type ctrl
  );
    logic enabled;
    enabled = select_active(ctrl.trigger1_select);
    if (ctrl.depth4_mode) begin
      enabled = 1'b1;
    end
    return enabled;
  endfunction : trigger1_enabled

  // Matches the affected silicon: any use of trigger 1 masks the event
  function automatic logic period_irq_enabled(
    input cap_pkg::slice_connection_control_type ctrl
  );
    logic enabled;
    enabled = 1'b1;
    if (ctrl.depth4_mode) begin
      enabled = 1'b0;
    end else if (select_active(ctrl.trigger1_select)) begin
      enabled = 1'b0;
    end
    return enabled;
  endfunction : period_irq_enabled

  //////////////////////////////////////////////////////////////////////////
  // Timer and FIFO helpers

  // A period lowered below the count lets the timer roll over first
  function automatic value_type timer_next(
    input value_type count,
    input logic      wrap
  );
    value_type result;
    if (wrap) begin
      result = cap_pkg::TIMER_RST;
    end else begin
      result = count + 16'h0001;
    end
    return result;
  endfunction : timer_next

  // Entry 1 newest, entry 0 oldest; a full pair drops its oldest value
  function automatic pair_type push_pair(
    input pair_type  entries,
    input value_type value
  );
    pair_type result;
    result[0] = entries[1];
    result[1] = value;
    return result;
  endfunction : push_pair

  function automatic logic [1:0] mark_pair(
    input logic [1:0] flags
  );
    return {1'b1, flags[1]};
  endfunction : mark_pair

  // Top entry newest, entry 0 oldest
  function automatic quad_type push_quad(
    input quad_type  entries,
    input value_type value
  );
    quad_type result;
    for (int i = 0; i < cap_pkg::NUM_REGS - 1; i++) begin
      result[i] = entries[i+1];
    end
    result[cap_pkg::NUM_REGS-1] = value;
    return result;
  endfunction : push_quad

  function automatic logic [cap_pkg::NUM_REGS-1:0] mark_quad(
    input logic [cap_pkg::NUM_REGS-1:0] flags
  );
    return {1'b1, flags[cap_pkg::NUM_REGS-1:1]};
  endfunction : mark_quad

  //////////////////////////////////////////////////////////////////////////
  // Trigger qualification
  logic t0_used;
  logic t1_used;
  logic t0_fire;
  logic t1_fire;
  logic irq_allowed;
  logic at_period;

  assign t0_used     = trigger0_enabled(ctrl_i);
  assign t1_used     = trigger1_enabled(ctrl_i);
  assign t0_fire     = t0_used && trigger0_i;
  assign t1_fire     = t1_used && trigger1_i;
  assign irq_allowed = period_irq_enabled(ctrl_i);
  assign at_period   = ctrl_i.timer_run && (s_q.timer == period_i);

  //////////////////////////////////////////////////////////////////////////
  // Depth-2 pairs: trigger 0 owns entries 1..0, trigger 1 owns 3..2
  logic [1:0]      pair_fire;
  pair_type [1:0]  pair_cap_d;
  logic [1:0][1:0] pair_full_d;

  assign pair_fire = {t1_fire, t0_fire};

  for (genvar p = 0; p < 2; p++) begin : g_pair
    assign pair_cap_d[p] = push_pair(s_q.cap[2*p+1 -: 2], s_q.timer);
    assign pair_full_d[p] = mark_pair(s_q.full[2*p+1 -: 2]);
  end

  //////////////////////////////////////////////////////////////////////////
  // Depth-4 chain over all entries
  quad_type                     quad_cap_d;
  logic [cap_pkg::NUM_REGS-1:0] quad_full_d;

  assign quad_cap_d  = push_quad(s_q.cap, s_q.timer);
  assign quad_full_d = mark_quad(s_q.full);

  //////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    s_d              = s_q;
    s_d.period_irq   = 1'b0;
    s_d.period_match = at_period;
    if (ctrl_i.timer_run) begin
      s_d.timer = timer_next(s_q.timer, at_period);
    end
    if (at_period && irq_allowed) begin
      s_d.period_irq = 1'b1;
    end
    if (ctrl_i.depth4_mode) begin
      if (t1_fire) begin
        s_d.cap  = quad_cap_d;
        s_d.full = quad_full_d;
      end
    end else begin
      if (pair_fire[0]) begin
        s_d.cap[1:0]  = pair_cap_d[0];
        s_d.full[1:0] = pair_full_d[0];
      end
      if (pair_fire[1]) begin
        s_d.cap[3:2]  = pair_cap_d[1];
        s_d.full[3:2] = pair_full_d[1];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs straight from state
  assign cap_o        = s_q.cap;
  assign full_o       = s_q.full;
  assign timer_o      = s_q.timer;
  assign period_irq_o = s_q.period_irq;

endmodule : timer_slice_capture_fifo

// *** bench/trig_src.sv ***
// Capture trigger source model
`timescale 1ns/1ns
module trig_src (
  input  logic        clk_i,
  input  logic [15:0] timer_i,
  output logic [1:0]  pulse_o
);
  logic [15:0] seen[$];
  initial pulse_o = 2'h0;
  task fire(input logic [1:0] m, input int n);
    repeat (n) begin
      @(posedge clk_i) pulse_o <= m;
      #1 seen.push_back(timer_i);
    end
    @(posedge clk_i) pulse_o <= 2'h0;
  endtask : fire
endmodule : trig_src

// *** bench/timer_slice_capture_fifo_checker.sv ***
// Port assertions of the capture block
`timescale 1ns/1ns
module cap_chk (
  input logic ref_clk_i,
  input logic rst_i,
  input cap_pkg::slice_connection_control_type ctrl_i,
  input logic [15:0] period_i,
  input logic trigger0_i,
  input logic trigger1_i,
  input logic [3:0][15:0] cap_o,
  input logic [3:0] full_o,
  input logic [15:0] timer_o,
  input logic period_irq_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  wire d = ctrl_i.depth4_mode;
  wire s = d | (|ctrl_i.trigger1_select);
  wire z = trigger0_i & !d & (|ctrl_i.trigger0_select);
  wire f = trigger1_i & d;
  wire w = ctrl_i.timer_run & (timer_o == period_i);
  a_zero_take: assert property (z |=> cap_o[1]==$past(timer_o))
    else $error("cap1");
  a_pair_shift: assert property (z |=> cap_o[0]==$past(cap_o[1]))
    else $error("cap0");
  a_zero_gate: assert property (!z & !d |=> $stable(cap_o[1:0]))
    else $error("gate");
  a_one_take: assert property (trigger1_i & s |=> cap_o[3]==$past(timer_o))
    else $error("cap3");
  a_deep_fifo: assert property (f |=> cap_o[2:0]==$past(cap_o[3:1]))
    else $error("deep");
  a_irq_cut: assert property (w & s |=> !period_irq_o)
    else $error("irq");
  a_full_mark: assert property (z |=> full_o[1])
    else $error("full");
  a_irq_raise: assert property (w & !s |=> period_irq_o)
    else $error("irq raise");
  a_timer_wrap: assert property (w |=> timer_o == 16'h0000)
    else $error("wrap");
  a_timer_step: assert property (
    ctrl_i.timer_run & !w |=> timer_o == $past(timer_o) + 16'h0001)
    else $error("step");
endmodule : cap_chk
bind timer_slice_capture_fifo cap_chk cap_chk_inst (.ref_clk_i, .rst_i,
  .ctrl_i, .period_i, .trigger0_i, .trigger1_i, .cap_o, .full_o, .timer_o,
  .period_irq_o);

// *** bench/test_timer_slice_capture_fifo.sv ***
// Capture block testbench
`timescale 1ns/1ns
module test_timer_slice_capture_fifo;
  logic ref_clk_i = 0;
  logic rst_i = 1;
  logic irq;
  logic [1:0] t;
  logic [3:0][15:0] cap;
  logic [15:0] tv;
  logic [15:0] n;
  logic [3:0] full;
  cap_pkg::slice_connection_control_type ctrl = '0;
  int bad_count = 0, num_checks = 0, cyc = 0;
  initial forever #2 ref_clk_i = ~ref_clk_i;
  trig_src trig_src_inst (.clk_i(ref_clk_i), .timer_i(tv), .pulse_o(t));
  timer_slice_capture_fifo timer_slice_capture_fifo_inst (.ref_clk_i,
    .rst_i, .ctrl_i(ctrl), .period_i(16'h0005), .trigger0_i(t[0]),
    .trigger1_i(t[1]), .cap_o(cap), .full_o(full), .timer_o(tv),
    .period_irq_o(irq));
  task cmp(string s, logic [15:0] e, logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s exp %h got %h", s, e, g);
    end
  endtask : cmp
  task summarize;
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize
  always @(posedge ref_clk_i) if (++cyc > 999) begin
    bad_count++;
    summarize;
  end
  task dual;
    @(posedge ref_clk_i) ctrl <= 6'h15;
    trig_src_inst.fire(2'h3, 2);
    #1 cmp("cap1", trig_src_inst.seen[1], cap[1]);
    cmp("cap0", trig_src_inst.seen[0], cap[0]);
    cmp("cap3", trig_src_inst.seen[1], cap[3]);
    cmp("cap2", trig_src_inst.seen[0], cap[2]);
    cmp("full", 16'h000f, {12'h000, full});
  endtask : dual
  task deep;
    @(posedge ref_clk_i) ctrl <= 6'h13;
    trig_src_inst.fire(2'h3, 4);
    #1 for (int k = 0; k < 4; k++) begin
      cmp("deep", trig_src_inst.seen[k+2], cap[k]);
    end
  endtask : deep
  task irqs(logic [5:0] c, logic [15:0] e);
    @(posedge ref_clk_i) ctrl <= c;
    n = 16'h0000;
    repeat (12) @(posedge ref_clk_i) #1 n += irq;
    cmp("irq", e, n);
  endtask : irqs
  task reinit;
    @(posedge ref_clk_i) rst_i <= 1;
    repeat (2) @(posedge ref_clk_i);
    rst_i <= 0;
    #1 cmp("cap", 16'h0000, cap[0] | cap[1] | cap[2] | cap[3]);
    cmp("full", 16'h0000, {12'h000, full});
    cmp("timer", 16'h0000, tv);
    cmp("irq", 16'h0000, {15'h0000, irq});
  endtask : reinit
  task sparse;
    trig_src_inst.fire(2'h1, 1);
    #1 cmp("cap1", 16'h0001, cap[1]);
    cmp("cap0", 16'h0000, cap[0]);
    cmp("full", 16'h0002, {12'h000, full});
    irqs(6'h11, 16'h2);
  endtask : sparse
  initial begin
    repeat (5) @(posedge ref_clk_i);
    rst_i <= 0;
    dual;
    deep;
    irqs(6'h13, 16'h0);
    for (int i = 1; i < 4; i++) irqs({2'h1, i[1:0], 2'h1}, 16'h0);
    irqs(6'h11, 16'h2);
    reinit;
    sparse;
    summarize;
  end
endmodule : test_timer_slice_capture_fifo
